// File: scbm_pkg.sv
package scbm_pkg;
	// Operation codes handed over by the decode path
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_EXCEPTION_RETURN = 4'h1,
		OP_POWER_DOWN = 4'h2,
		OP_LOAD_FLAGS_IMM = 4'h3,
		OP_LOAD_FLAGS_REG = 4'h4,
		OP_STORE_FLAGS = 4'h5,
		OP_FLAGS_AND = 4'h6,
		OP_FLAGS_OR = 4'h7,
		OP_FLAGS_XOR = 4'h8,
		OP_NO_OPERATION = 4'h9,
		OP_BLOCK_MOVE = 4'hA
	} scbm_op_type;

	// Power-down choices
	typedef enum logic [1:0] {
		PD_NONE = 2'h0,
		PD_SLEEP = 2'h1,
		PD_SOFT_STANDBY = 2'h2
	} scbm_pd_type;

	// One decoded instruction
	typedef struct packed {
		scbm_op_type op;
		logic [7:0] immData;
		logic [7:0] regData;
		logic [2:0] regIndex;
	} scbm_instr_type;

	// Byte bus request from the copier
	typedef struct packed {
		logic read;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} scbm_bus_req_type;

	localparam logic [15:0] SCBM_PC_STEP = 16'h0002;
	localparam logic [7:0] SCBM_FLAGS_RESET = 8'h80;
	localparam logic [7:0] SCBM_COUNT_ZERO = 8'h00;
	localparam int SCBM_BLOCK_COUNT_REG = 4;
	localparam int SCBM_BLOCK_SRC_REG = 5;
	localparam int SCBM_BLOCK_DST_REG = 6;
endpackage : scbm_pkg

// File: scbm_block_copier.sv
`timescale 1ns/1ps
// Byte-by-byte block copier: read source, write destination, repeat
module scbm_block_copier
	import scbm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] countIn,
	input wire logic [15:0] srcIn,
	input wire logic [15:0] dstIn,
	output scbm_pkg::scbm_bus_req_type busReq,
	input wire logic busAck,
	input wire logic [7:0] busRdata,
	output logic busy,
	output logic done,
	output logic [7:0] countOut,
	output logic [15:0] srcOut,
	output logic [15:0] dstOut
);
	typedef enum logic [2:0] {
		CP_IDLE = 3'b001,
		CP_READ = 3'b010,
		CP_WRITE = 3'b100
	} scbm_cp_type;

	scbm_cp_type state_reg, state_next;
	logic [7:0] count_reg, count_next;
	logic [15:0] src_reg, src_next;
	logic [15:0] dst_reg, dst_next;
	logic [7:0] data_reg, data_next;
	logic done_reg, done_next;
	wire logic lastByte = (count_reg == 8'h01);

	// Next-state logic; zero count finishes at once
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		src_next = src_reg;
		dst_next = dst_reg;
		data_next = data_reg;
		done_next = 1'b0;
		case (state_reg)
			CP_IDLE: begin
				if (start) begin
					count_next = countIn;
					src_next = srcIn;
					dst_next = dstIn;
					if (countIn == SCBM_COUNT_ZERO) begin
						done_next = 1'b1;
					end else begin
						state_next = CP_READ;
					end
				end
			end
			CP_READ: begin
				if (busAck) begin
					data_next = busRdata;
					src_next = src_reg + 16'h0001;
					state_next = CP_WRITE;
				end
			end
			CP_WRITE: begin
				if (busAck) begin
					// Pointer wrap past the top is the caller's problem
					dst_next = dst_reg + 16'h0001;
					count_next = count_reg - 8'h01;
					if (lastByte) begin
						state_next = CP_IDLE;
						done_next = 1'b1;
					end else begin
						state_next = CP_READ;
					end
				end
			end
			default: state_next = CP_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= CP_IDLE;
			count_reg <= 8'h00;
			src_reg <= 16'h0000;
			dst_reg <= 16'h0000;
			data_reg <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			src_reg <= src_next;
			dst_reg <= dst_next;
			data_reg <= data_next;
			done_reg <= done_next;
		end
	end

	// Bus requests are combinational handshakes
	assign busReq.read = (state_reg == CP_READ);
	assign busReq.write = (state_reg == CP_WRITE);
	assign busReq.addr = (state_reg == CP_WRITE) ? dst_reg : src_reg;
	assign busReq.wdata = data_reg;
	assign busy = (state_reg != CP_IDLE);
	assign done = done_reg;
	assign countOut = count_reg;
	assign srcOut = src_reg;
	assign dstOut = dst_reg;

	a_copy_post_inc: assert property (@(posedge clk) disable iff (rst)
		(state_reg == CP_WRITE && busAck) |=> dst_reg == $past(dst_reg)
		+ 16'h0001) else $error("destination pointer not incremented");
	a_zero_count_skip: assert property (@(posedge clk) disable iff (rst)
		(state_reg == CP_IDLE && start && countIn == 8'h00)
		|=> (done && !busy)) else $error("zero count did not finish");
endmodule : scbm_block_copier

// File: scbm_exec.sv
`timescale 1ns/1ps
// Functional notes
// - Exception return resumes the interrupted program
// - Power-down instruction stops execution, enters power-down
// - Standby bit picks sleep or software standby
// - Load flags from immediate or register byte
// - Store flags into destination register
// - Flags AND immediate replaces flags
// - Flags OR immediate replaces flags
// - Flags XOR immediate replaces flags
// - No-operation only advances program counter by two
// - Block move copies bytes, post-increments, zero skips
// - Count, source, destination from registers 4,5,6
// - Next instruction waits for block completion
module scbm_exec
	import scbm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input scbm_pkg::scbm_instr_type instr,
	input wire logic instrValid,
	output logic instrReady,
	input wire logic [15:0] pcIn,
	input wire logic softStandbySelect,
	input wire logic [7:0] blockCountByte,
	input wire logic [15:0] blockSourcePtr,
	input wire logic [15:0] blockDestPtr,
	output scbm_pkg::scbm_bus_req_type busReq,
	input wire logic busAck,
	input wire logic [7:0] busRdata,
	output logic [7:0] conditionFlags,
	output logic [15:0] pcOut,
	output logic pcWrite,
	output logic regWrite,
	output logic [2:0] regWriteIndex,
	output logic [7:0] regWriteData,
	output logic blockRegWrite,
	output logic [7:0] blockCountOut,
	output logic [15:0] blockSourceOut,
	output logic [15:0] blockDestOut,
	output logic exceptionReturn,
	output scbm_pkg::scbm_pd_type powerDown,
	output logic powerDownActive
);
	logic [7:0] flags_reg, flags_next;
	logic [15:0] pc_reg, pc_next;
	logic pcWrite_reg, pcWrite_next;
	logic regWrite_reg, regWrite_next;
	logic [2:0] regIdx_reg, regIdx_next;
	logic [7:0] regData_reg, regData_next;
	logic excRet_reg, excRet_next;
	scbm_pd_type pd_reg, pd_next;
	logic copyBusy;
	logic copyDone;

	// Instruction accepted when idle and not halted
	wire logic take = instrValid && instrReady;
	wire logic isOp = take && instr.op != OP_BLOCK_MOVE;
	wire logic startMove = take && instr.op == OP_BLOCK_MOVE;
	assign instrReady = !copyBusy && (pd_reg == PD_NONE);

	// Flag arithmetic; whole byte replaced at once
	wire logic [7:0] flagsAnd = flags_reg & instr.immData;
	wire logic [7:0] flagsOr = flags_reg | instr.immData;
	wire logic [7:0] flagsXor = flags_reg ^ instr.immData;

	// Per-op results; anything unlisted leaves state alone
	always_comb begin
		flags_next = flags_reg;
		pc_next = pc_reg;
		pcWrite_next = 1'b0;
		regWrite_next = 1'b0;
		regIdx_next = regIdx_reg;
		regData_next = regData_reg;
		excRet_next = 1'b0;
		pd_next = pd_reg;
		if (isOp) begin
			case (instr.op)
				OP_EXCEPTION_RETURN: excRet_next = 1'b1;
				OP_POWER_DOWN: begin
					// Only the standby bit chooses the mode
					pd_next = softStandbySelect ? PD_SOFT_STANDBY
						: PD_SLEEP;
				end
				OP_LOAD_FLAGS_IMM: flags_next = instr.immData;
				OP_LOAD_FLAGS_REG: flags_next = instr.regData;
				OP_STORE_FLAGS: begin
					regWrite_next = 1'b1;
					regIdx_next = instr.regIndex;
					regData_next = flags_reg;
				end
				OP_FLAGS_AND: flags_next = flagsAnd;
				OP_FLAGS_OR: flags_next = flagsOr;
				OP_FLAGS_XOR: flags_next = flagsXor;
				OP_NO_OPERATION: begin
					pc_next = pcIn + SCBM_PC_STEP;
					pcWrite_next = 1'b1;
				end
				default: ;
			endcase
		end
	end

	// Registered results
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_reg <= SCBM_FLAGS_RESET;
			pc_reg <= 16'h0000;
			pcWrite_reg <= 1'b0;
			regWrite_reg <= 1'b0;
			regIdx_reg <= 3'h0;
			regData_reg <= 8'h00;
			excRet_reg <= 1'b0;
			pd_reg <= PD_NONE;
		end else begin
			flags_reg <= flags_next;
			pc_reg <= pc_next;
			pcWrite_reg <= pcWrite_next;
			regWrite_reg <= regWrite_next;
			regIdx_reg <= regIdx_next;
			regData_reg <= regData_next;
			excRet_reg <= excRet_next;
			pd_reg <= pd_next;
		end
	end

	// Copier takes registers 4, 5, 6 straight from the file
	scbm_block_copier copier (
		.clk(clk),
		.rst(rst),
		.start(startMove),
		.countIn(blockCountByte),
		.srcIn(blockSourcePtr),
		.dstIn(blockDestPtr),
		.busReq(busReq),
		.busAck(busAck),
		.busRdata(busRdata),
		.busy(copyBusy),
		.done(copyDone),
		.countOut(blockCountOut),
		.srcOut(blockSourceOut),
		.dstOut(blockDestOut)
	);

	assign conditionFlags = flags_reg;
	assign pcOut = pc_reg;
	assign pcWrite = pcWrite_reg;
	assign regWrite = regWrite_reg;
	assign regWriteIndex = regIdx_reg;
	assign regWriteData = regData_reg;
	assign blockRegWrite = copyDone;
	assign exceptionReturn = excRet_reg;
	assign powerDown = pd_reg;
	assign powerDownActive = (pd_reg != PD_NONE);

	a_flags_and_op: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_FLAGS_AND) |=> conditionFlags ==
		($past(conditionFlags) & $past(instr.immData)))
		else $error("flags AND wrong");
	a_flags_or_op: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_FLAGS_OR) |=> conditionFlags ==
		($past(conditionFlags) | $past(instr.immData)))
		else $error("flags OR wrong");
	a_flags_xor_op: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_FLAGS_XOR) |=> conditionFlags ==
		($past(conditionFlags) ^ $past(instr.immData)))
		else $error("flags XOR wrong");
	a_load_flags_imm: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_LOAD_FLAGS_IMM) |=>
		conditionFlags == $past(instr.immData))
		else $error("load flags wrong");
	a_store_flags_op: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_STORE_FLAGS) |=> regWrite &&
		regWriteData == $past(conditionFlags))
		else $error("store flags wrong");
	a_nop_pc_step: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_NO_OPERATION) |=> pcWrite &&
		pcOut == $past(pcIn) + 16'h0002 && !regWrite)
		else $error("no-operation step wrong");
	a_exc_return_pulse: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_EXCEPTION_RETURN) |=> exceptionReturn
		##1 !exceptionReturn) else $error("exception return bad");
	a_sleep_mode_pick: assert property (@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_POWER_DOWN) |=> powerDown ==
		($past(softStandbySelect) ? PD_SOFT_STANDBY : PD_SLEEP))
		else $error("power-down mode wrong");
	a_move_blocks_next: assert property (@(posedge clk) disable iff (rst)
		copyBusy |-> !instrReady) else $error("instruction during move");
	a_flags_reg_load: assert property (
		@(posedge clk) disable iff (rst)
		(isOp && instr.op == OP_LOAD_FLAGS_REG) |=>
		conditionFlags == $past(instr.regData))
		else $error("register flag load wrong");
	// Halt is sticky: nothing else gets in until reset
	a_halt_refuses: assert property (
		@(posedge clk) disable iff (rst)
		powerDownActive |=> powerDownActive && !instrReady &&
		$stable(conditionFlags) && !pcWrite && !regWrite)
		else $error("op taken while powered down");
	// No-operation and store-flags ops must not disturb the flags
	a_flags_kept_other: assert property (
		@(posedge clk) disable iff (rst)
		(isOp && (instr.op == OP_NO_OPERATION ||
		instr.op == OP_STORE_FLAGS)) |=> $stable(conditionFlags))
		else $error("flags changed by non-flag op");
	// Completion pulse only with the count used up
	a_move_done_count: assert property (
		@(posedge clk) disable iff (rst)
		blockRegWrite |->
		(blockCountOut == SCBM_COUNT_ZERO && instrReady))
		else $error("move finished with bytes left");

	c_block_move: cover property (@(posedge clk) disable iff (rst)
		startMove && blockCountByte != 8'h00 ##[1:20] copyDone);
	c_zero_move: cover property (@(posedge clk) disable iff (rst)
		startMove && blockCountByte == 8'h00);
	c_soft_standby: cover property (@(posedge clk) disable iff (rst)
		powerDown == PD_SOFT_STANDBY);
	c_exc_return: cover property (@(posedge clk) disable iff (rst)
		exceptionReturn);
endmodule : scbm_exec

// File: scbm_mem_model.sv
`timescale 1ns/1ps
// Byte memory answering the copier's bus
module scbm_mem_model
	import scbm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input scbm_pkg::scbm_bus_req_type busReq,
	input wire logic [3:0] readWait,
	output logic busAck,
	output logic [7:0] busRdata
);
	import scbm_pkg::*;
	logic [7:0] mem [0:255];
	logic [3:0] waitReg;
	logic [7:0] lastReg;
	// Fill pattern the bench can predict
	initial begin
		lastReg = 8'h00;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end
	// Reads may stall; writes never wait, so no waited last write
	// Plain always: the fill above also writes the array
	always @(posedge clk) begin
		if (rst || busAck) begin
			busAck <= 1'b0;
			waitReg <= 4'h0;
		end else if (busReq.write) begin
			busAck <= 1'b1;
			mem[busReq.addr[7:0]] <= busReq.wdata;
		end else if (busReq.read) begin
			if (waitReg == readWait) begin
				busAck <= 1'b1;
				lastReg <= mem[busReq.addr[7:0]];
			end else begin
				waitReg <= waitReg + 4'h1;
			end
		end
	end
	// Data is scrambled while busAck is low; a write ack shows the last read byte unscrambled
	assign busRdata = busAck ? lastReg : ~lastReg;
endmodule : scbm_mem_model

// File: system_control_block_move_exec_test.sv
`timescale 1ns/1ps
module system_control_block_move_exec_test;
	import scbm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	scbm_instr_type instr = '0;
	logic instrValid = 1'b0;
	logic [15:0] pcIn = 16'h1234;
	logic sbySel = 1'b0;
	logic [7:0] cnt = 8'h00;
	logic [15:0] src = 16'h0000;
	logic [15:0] dst = 16'h0000;
	logic [3:0] readWait = 4'h0;
	scbm_bus_req_type busReq;
	logic busAck, pcWrite, regWrite, blkWr, excRet, pdAct, instrReady;
	logic [7:0] flags, busRdata, regData, cntOut;
	logic [15:0] pcOut, srcOut, dstOut;
	logic [2:0] regIdx;
	scbm_pd_type pd;
	int n_errors = 0;
	int n_tests = 0;
	// Half period of the 50 MHz clock
	always #10 clk = ~clk;
	scbm_exec u_dut (.clk(clk), .rst(rst), .instr(instr),
		.instrValid(instrValid), .instrReady(instrReady), .pcIn(pcIn),
		.softStandbySelect(sbySel), .blockCountByte(cnt),
		.blockSourcePtr(src), .blockDestPtr(dst), .busReq(busReq),
		.busAck(busAck), .busRdata(busRdata), .conditionFlags(flags),
		.pcOut(pcOut), .pcWrite(pcWrite), .regWrite(regWrite),
		.regWriteIndex(regIdx), .regWriteData(regData),
		.blockRegWrite(blkWr), .blockCountOut(cntOut),
		.blockSourceOut(srcOut), .blockDestOut(dstOut),
		.exceptionReturn(excRet), .powerDown(pd), .powerDownActive(pdAct));
	scbm_mem_model u_mem (.clk(clk), .rst(rst), .busReq(busReq),
		.readWait(readWait), .busAck(busAck), .busRdata(busRdata));
	task automatic close_out;
		if (n_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Offer one op at a falling edge; return at the falling edge half a cycle after the take
	task automatic op(input scbm_op_type o, input logic [7:0] imm);
		instr = '{o, imm, 8'h3C, 3'h2};
		instrValid = 1'b1;
		@(posedge clk);
		@(negedge clk);
	endtask : op
	task automatic do_reset;
		instrValid = 1'b0;
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
	endtask : do_reset
	// Flag ops issued back to back, each seen by the next
	task automatic t_flags;
		chk(flags, SCBM_FLAGS_RESET);
		op(OP_LOAD_FLAGS_IMM, 8'hA5);
		chk(flags, 16'h00A5);
		op(OP_FLAGS_AND, 8'h0F);
		chk(flags, 16'h0005);
		op(OP_FLAGS_OR, 8'h90);
		chk(flags, 16'h0095);
		op(OP_FLAGS_XOR, 8'hFF);
		chk(flags, 16'h006A);
		op(OP_LOAD_FLAGS_REG, 8'h00);
		chk(flags, 16'h003C);
		op(OP_STORE_FLAGS, 8'h00);
		chk({regWrite, regIdx, 4'h0, regData}, 16'hA03C);
		op(OP_NO_OPERATION, 8'h00);
		chk({pcWrite, regWrite, flags}, 16'h023C);
		chk(pcOut, 16'h1236);
		op(OP_EXCEPTION_RETURN, 8'h00);
		instrValid = 1'b0;
		chk({excRet, pcWrite}, 16'h0002);
	endtask : t_flags
	// Copy n bytes to d with slow reads; bench keeps d+n within range
	task automatic t_move(input logic [7:0] n, input logic [15:0] d);
		int k;
		readWait = 4'h3;
		cnt = n;
		src = 16'h0010;
		dst = d;
		op(OP_BLOCK_MOVE, 8'h00);
		instrValid = 1'b0;
		for (k = 0; k < 200 && blkWr !== 1'b1; k++) begin
			chk(instrReady, 16'h0000);
			@(negedge clk);
		end
		chk({blkWr, instrReady, cntOut}, 16'h0300);
		chk(srcOut, 16'h0010 + n);
		chk(dstOut, d + n);
		// Byte past the block must keep its fill pattern
		for (k = 0; k <= n; k++) begin
			chk(u_mem.mem[d[7:0] + k],
				(k < n) ? (8'h10 + k) ^ 8'h5A : (d[7:0] + k) ^ 8'h5A);
		end
		@(negedge clk);
	endtask : t_move
	// Power-down refuses further ops until reset
	task automatic t_power(input logic sel, input scbm_pd_type exp,
		input logic [7:0] keep);
		sbySel = sel;
		op(OP_POWER_DOWN, 8'h00);
		chk({pd, pdAct, instrReady}, {12'h000, exp, 2'b10});
		instr = '{OP_LOAD_FLAGS_IMM, 8'h11, 8'h00, 3'h0};
		repeat (3) @(negedge clk);
		chk(flags, keep);
		do_reset;
	endtask : t_power
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		t_flags;
		t_move(8'h03, 16'h0040);
		t_move(8'h00, 16'h0080);
		t_power(1'b0, PD_SLEEP, 8'h3C);
		t_power(1'b1, PD_SOFT_STANDBY, SCBM_FLAGS_RESET);
		close_out;
	end
	// Watchdog well past the expected run length
	initial begin
		#200000;
		n_errors++;
		close_out;
	end
endmodule : system_control_block_move_exec_test
